/* File: sense_map.vh */
// register offsets, bit positions and sizes for status and sense reporting
`ifndef SENSE_MAP_VH
`define SENSE_MAP_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define A_STAT 12'h000
`define A_SIDX 12'h004
`define A_SDAT 12'h008
`define A_CTRL 12'h00C
// ----------------------------------------
// status byte: position n sits at index 7-n
// ----------------------------------------
`define ST_SM 6
`define ST_CUE 5
`define ST_BUSY 4
`define ST_CE 3
`define ST_DE 2
`define ST_UC 1
`define ST_UE 0
// ----------------------------------------
// sense byte 0 flags, bit n at index 7-n
// ----------------------------------------
`define SB_REJ 7
`define SB_INT 6
`define SB_BOP 5
`define SB_EQC 4
`define SB_DCK 3
`define SB_OVR 2
`define SB2_CORR 6
`define SN_LEN 24
`define SN_LAST 5'h17
`define SN_B0 0
`define SN_B2 2
`define CT_SHARED 0
`define CT_DIAG 1
`define B0_DEF 8'h00
`endif

/* File: sense_report.v */
// status byte composition and 24-byte sense record for the storage control unit
// How it works
// - selection reject gives unit check alone
// - unit check ending suppresses command chaining
// - late check rides with matching ending bit
// - check after device end uses control-unit end
// - shared unit holds sense until device end
// - busy drive: busy status, never unit check
// - not ready ignored for sense or pending
// - not ready mid-command raises no check
// - unit exception rides ending bit, suppresses chaining
// - unit exception sets no sense
// - non-busy command clears sense, except sense/test
// - sense command sends exactly 24 bytes
// - byte 7 high nibble holds format
// - byte 0 holds six independent flags
// - reject flag for bad or illegal command
// - intervention flag for not ready or diagnostics
// - parity flag; write continues unless fatal
// - equipment flag; fatal fault stops transfer
// - correctable error also sets byte 2 bit 1
// - count field error checks, key field not
// - correct parity on bytes to channel
// - overrun flag and transfer stop
// - unit check bit 6, exception bit 7
// - unit-level busy carries status modifier
`timescale 1ns/100ps
`default_nettype none
`include "sense_map.vh"
module sense_report (
  input wire core_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sel_req,
  input wire sel_bad,
  input wire sel_sense,
  input wire sel_test,
  input wire sel_diag,
  input wire sel_drv_busy,
  input wire sel_pending,
  input wire [7:0] sel_pend_st,
  input wire sel_cu_busy,
  input wire sel_not_ready,
  input wire sel_nr_ok,
  input wire sel_no_data,
  input wire end_ce,
  input wire end_cue,
  input wire end_de,
  input wire err_reject,
  input wire err_parity,
  input wire err_equip,
  input wire err_fatal,
  input wire err_corr,
  input wire err_uncorr,
  input wire err_count,
  input wire err_key,
  input wire err_overrun,
  input wire ex_event,
  input wire st_take,
  input wire de_accept,
  input wire sense_start,
  input wire sense_take,
  output reg [7:0] st_byte,
  output reg st_par,
  output reg st_valid,
  output reg chain_sup,
  output reg stop_xfer,
  output reg hold_path,
  output reg [7:0] sense_byte,
  output reg sense_par,
  output reg sense_valid
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [7:0] sense_q [0:`SN_LEN-1];
  reg [4:0] sidx_q;
  reg [1:0] ctrl_q;
  reg active_q;
  reg uc_pend_q;
  reg ue_pend_q;
  reg [4:0] scnt_q;
  reg [4:0] scnt_d;
  reg [7:0] st_d;
  reg st_new;
  reg clr_sense;
  reg [7:0] b0_set;
  reg uc_sel;
  reg accept_sel;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire late_err;
  wire any_end;

  // key field errors never reach the record
  assign late_err = err_reject | err_parity | err_equip | err_corr
    | err_uncorr | err_count | err_overrun;
  assign any_end = end_ce | end_cue | end_de;

  // ----------------------------------------
  // initial selection and ending status
  // ----------------------------------------
  always @* begin
    st_d = 8'h00;
    st_new = 1'b0;
    clr_sense = 1'b0;
    b0_set = 8'h00;
    uc_sel = 1'b0;
    accept_sel = 1'b0;

    if (sel_req) begin
      st_new = 1'b1;
      // busy outranks every check of the command
      if (sel_drv_busy | sel_pending) begin
        // code validity is not judged here
        st_d = sel_pend_st;
        st_d[`ST_BUSY] = 1'b1;
        st_d[`ST_UC] = 1'b0;
        st_d[`ST_SM] = sel_cu_busy;
      end else if (sel_cu_busy) begin
        st_d[`ST_BUSY] = 1'b1;
        st_d[`ST_SM] = 1'b1;
      end else begin
        clr_sense = ~sel_sense & ~sel_test & ~hold_path;
        if (sel_bad) begin
          b0_set[`SB_REJ] = 1'b1;
          uc_sel = 1'b1;
        end
        if (sel_not_ready & ~sel_sense & ~sel_nr_ok) begin
          b0_set[`SB_INT] = 1'b1;
          uc_sel = 1'b1;
        end
        if (sel_diag & ~ctrl_q[`CT_DIAG]) begin
          b0_set[`SB_INT] = 1'b1;
          uc_sel = 1'b1;
        end
        if (uc_sel) begin
          // a rejected command takes no action at the drive
          st_d[`ST_UC] = 1'b1;
        end else begin
          accept_sel = 1'b1;
          st_d[`ST_CE] = sel_no_data;
          st_d[`ST_DE] = sel_no_data;
        end
      end
    end else if (any_end) begin
      st_new = 1'b1;
      st_d[`ST_CE] = end_ce;
      st_d[`ST_CUE] = end_cue;
      st_d[`ST_DE] = end_de;
      st_d[`ST_UC] = uc_pend_q | late_err;
      st_d[`ST_UE] = ue_pend_q | ex_event;
    end else if (late_err & ~active_q) begin
      // errors with no operation running report at once
      st_new = 1'b1;
      st_d[`ST_UC] = 1'b1;
      st_d[`ST_CUE] = 1'b1;
    end

    if (late_err) begin
      b0_set[`SB_REJ] = b0_set[`SB_REJ] | err_reject;
      b0_set[`SB_BOP] = err_parity;
      b0_set[`SB_EQC] = err_equip;
      b0_set[`SB_DCK] = err_corr | err_uncorr | err_count;
      b0_set[`SB_OVR] = err_overrun;
    end
  end

  // ----------------------------------------
  // sense record, one register per byte
  // ----------------------------------------
  // one register per byte lets a clear reach all bytes at once
  genvar gi;
  generate
    for (gi = 0; gi < `SN_LEN; gi = gi + 1) begin : g_sense
      always @(posedge core_clk) begin
        if (srst) begin
          sense_q[gi] <= `B0_DEF;
        end else if (wr && paddr == `A_SDAT && sidx_q == gi) begin
          // format nibble of byte 7 and detail bytes come from here
          sense_q[gi] <= pwdata[7:0];
        end else if (gi == `SN_B0) begin
          // exception never touches the record
          sense_q[gi] <= (clr_sense ? `B0_DEF : sense_q[gi]) | b0_set;
        end else if (gi == `SN_B2) begin
          sense_q[gi] <= (clr_sense ? `B0_DEF : sense_q[gi])
            | ({8{err_corr}} & (8'h01 << `SB2_CORR));
        end else if (clr_sense) begin
          sense_q[gi] <= `B0_DEF;
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // operation tracking
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      active_q <= 1'b0;
    end else if (accept_sel & ~sel_no_data) begin
      active_q <= 1'b1;
    end else if (end_de | (accept_sel & sel_no_data)) begin
      active_q <= 1'b0;
    end
  end

  // not ready during a running command is not an error
  always @(posedge core_clk) begin
    if (srst) begin
      uc_pend_q <= 1'b0;
      ue_pend_q <= 1'b0;
    end else if (any_end | sel_req) begin
      uc_pend_q <= 1'b0;
      ue_pend_q <= 1'b0;
    end else begin
      uc_pend_q <= uc_pend_q | (late_err & active_q);
      ue_pend_q <= ue_pend_q | (ex_event & active_q);
    end
  end

  // ----------------------------------------
  // status byte to the channel
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      st_byte <= 8'h00;
      st_par <= 1'b1;
      st_valid <= 1'b0;
    end else if (st_new) begin
      // a newer status replaces one not yet taken
      st_byte <= st_d;
      st_par <= ~^st_d;
      st_valid <= 1'b1;
    end else if (st_take) begin
      st_valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // chaining, transfer stop and path hold
  // ----------------------------------------
  // set wins over the clear by the next selection
  always @(posedge core_clk) begin
    if (srst) begin
      chain_sup <= 1'b0;
    end else if (st_new & (st_d[`ST_UC] | st_d[`ST_UE] | st_d[`ST_BUSY])) begin
      chain_sup <= 1'b1;
    end else if (sel_req) begin
      chain_sup <= 1'b0;
    end
  end

  // parity alone lets a write run on
  always @(posedge core_clk) begin
    if (srst) begin
      stop_xfer <= 1'b0;
    end else begin
      stop_xfer <= err_overrun | (err_fatal & late_err);
    end
  end

  // sense and the drive path stay reserved until device end is taken
  always @(posedge core_clk) begin
    if (srst) begin
      hold_path <= 1'b0;
    end else if (st_new & st_d[`ST_UC] & st_d[`ST_CE] & ~st_d[`ST_DE]
                 & ctrl_q[`CT_SHARED]) begin
      hold_path <= 1'b1;
    end else if (de_accept) begin
      hold_path <= 1'b0;
    end
  end

  // ----------------------------------------
  // sense transfer to the channel
  // ----------------------------------------
  // the count restarts on every sense command
  always @* begin
    scnt_d = scnt_q;
    if (sense_start) begin
      scnt_d = 5'h00;
    end else if (sense_valid & sense_take) begin
      scnt_d = scnt_q + 5'h01;
    end
  end

  // the byte follows the next count so it stands with valid
  always @(posedge core_clk) begin
    if (srst) begin
      scnt_q <= 5'h00;
      sense_valid <= 1'b0;
      sense_byte <= 8'h00;
      sense_par <= 1'b1;
    end else begin
      scnt_q <= scnt_d;
      if (sense_start) begin
        sense_valid <= 1'b1;
      end else if (sense_valid & sense_take & scnt_q == `SN_LAST) begin
        sense_valid <= 1'b0;
      end
      if (scnt_d <= `SN_LAST) begin
        sense_byte <= sense_q[scnt_d];
        sense_par <= ~^sense_q[scnt_d];
      end
    end
  end

  // ----------------------------------------
  // apb slave, one wait state
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      // data is latched one cycle ahead so it stands with pready
      if (psel & penable & ~pready) begin
        // refused addresses answer with an error and zero data
        case (paddr)
          `A_STAT: begin
            prdata <= {20'h0_0000, active_q, hold_path,
                       chain_sup, st_valid, st_byte};
          end
          `A_SIDX: begin
            prdata <= {27'h000_0000, sidx_q};
          end
          `A_SDAT: begin
            prdata <= {24'h00_0000, sense_q[sidx_q]};
          end
          `A_CTRL: begin
            prdata <= {30'h0000_0000, ctrl_q};
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // an index past the last sense byte is ignored
  always @(posedge core_clk) begin
    if (srst) begin
      sidx_q <= 5'h00;
      ctrl_q <= 2'b00;
    end else begin
      if (wr && paddr == `A_SIDX && pwdata[4:0] <= `SN_LAST) begin
        sidx_q <= pwdata[4:0];
      end
      if (wr && paddr == `A_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end
    end
  end
endmodule
`default_nettype wire

/* File: sense_chk_sva.sv */
// checker for status byte, chaining, hold and parity behaviour
`timescale 1ns/100ps
`default_nettype none
`include "sense_map.vh"
module sense_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sel_req,
  input wire logic sel_bad,
  input wire logic sel_sense,
  input wire logic sel_drv_busy,
  input wire logic sel_pending,
  input wire logic sel_cu_busy,
  input wire logic err_overrun,
  input wire logic de_accept,
  input wire logic [7:0] st_byte,
  input wire logic st_par,
  input wire logic st_valid,
  input wire logic chain_sup,
  input wire logic stop_xfer,
  input wire logic hold_path
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  rej_alone_a: assert property (sel_req && sel_bad && !sel_drv_busy && !sel_pending && !sel_cu_busy
    |=> st_valid && st_byte == 8'h02) else $error("reject status wrong");
  uc_chain_a: assert property (st_valid && st_byte[`ST_UC] |-> ##[0:1] chain_sup)
    else $error("chaining not suppressed");
  busy_no_uc_a: assert property (sel_req && (sel_drv_busy || sel_pending)
    |=> st_byte[`ST_BUSY] && !st_byte[`ST_UC]) else $error("busy status wrong");
  cu_busy_sm_a: assert property (sel_req && sel_cu_busy |=> st_byte[`ST_BUSY] && st_byte[`ST_SM])
    else $error("unit busy without modifier");
  sense_nr_a: assert property (sel_req && sel_sense && !sel_bad |=> !st_byte[`ST_UC])
    else $error("check on sense command");
  xfer_stop_a: assert property (err_overrun |=> stop_xfer)
    else $error("overrun did not stop transfer");
  hold_clr_a: assert property (de_accept |=> !hold_path)
    else $error("path held after device end");
  par_odd_a: assert property (st_valid |-> st_par == ~^st_byte)
    else $error("status parity wrong");
  cover property (st_valid && st_byte[`ST_UE]);
  cover property (hold_path);
  cover property (stop_xfer);
endmodule
bind sense_report sense_chk u_chk (.*);
`default_nettype wire

/* File: host_chan.sv */
// host channel model that accepts status and sense bytes
`timescale 1ns/100ps
`default_nettype none
module host_chan (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic st_valid,
  input wire logic sense_valid,
  input wire logic [1:0] lag,
  output logic st_take = 1'b0,
  output logic sense_take = 1'b0,
  output int hc_n
);
  logic [1:0] cnt;
  always @(posedge core_clk) begin
    st_take <= 1'b0;
    sense_take <= 1'b0;
    if (srst) begin
      cnt <= 2'h0;
      hc_n <= 0;
    end else if ((sense_valid || st_valid) && !st_take && !sense_take) begin
      if (cnt != lag) begin
        cnt <= cnt + 2'h1;
      end else begin
        cnt <= 2'h0;
        sense_take <= sense_valid;
        st_take <= st_valid && !sense_valid;
        hc_n <= hc_n + (sense_valid ? 1 : 0);
      end
    end
  end
endmodule
`default_nettype wire

/* File: sense_report_bench.sv */
// testbench for status and sense reporting
`timescale 1ns/100ps
`default_nettype none
`include "sense_map.vh"
module sense_report_bench;
  logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, sel_req = 0, sel_bad = 0;
  logic sel_sense = 0, sel_test = 0, sel_diag = 0, sel_drv_busy = 0, sel_pending = 0, sel_cu_busy = 0;
  logic sel_not_ready = 0, sel_nr_ok = 0, sel_no_data = 0, end_ce = 0, end_cue = 0, end_de = 0;
  logic err_reject = 0, err_parity = 0, err_equip = 0, err_fatal = 0, err_corr = 0, err_uncorr = 0;
  logic err_count = 0, err_key = 0, err_overrun = 0, ex_event = 0, de_accept = 0, sense_start = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0] sel_pend_st = 0, st_byte, sense_byte;
  logic [1:0] lag = 0;
  logic pready, pslverr, st_take, sense_take, st_par, st_valid, chain_sup, stop_xfer, hold_path;
  logic sense_par, sense_valid, er;
  int fail_count = 0, total_checks = 0, hc_n;
  always #5 core_clk = ~core_clk;
  sense_report u_dut (.*);
  host_chan u_host (.*);
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge core_clk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick;
    penable <= 1;
    do begin
      tick;
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (k >= 20) begin
      fail_count++;
      summarize;
    end
    tick;
  endtask
  task sd(input logic [4:0] i, input logic [7:0] e);
    apb(1, `A_SIDX, {27'h0, i});
    apb(0, `A_SDAT, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  task sel;
    sel_req <= 1;
    tick;
    {sel_req, sel_bad, sel_sense, sel_drv_busy, sel_cu_busy, sel_not_ready, sel_pend_st} <= 0;
    tick;
  endtask
  task endp;
    tick;
    {end_ce, end_cue, end_de, err_equip, err_corr, err_overrun, err_count, err_parity, err_key, err_fatal, ex_event,
     de_accept} <= 0;
    tick;
  endtask
  task t_reject;
    int k;
    sel_bad <= 1;
    sel;
    chk(st_byte, 8'h02);
    chk(st_valid, 1);
    chk(st_par, 0);
    chk(chain_sup, 1);
    sd(0, 8'h80);
    lag <= 2;
    k = hc_n;
    sense_start <= 1;
    tick;
    sense_start <= 0;
    tick;
    chk(sense_byte, 8'h80);
    chk(sense_par, 0);
    for (int i = 0; i < 200 && (sense_valid !== 1'b0 || i < 2); i++) tick;
    chk(hc_n - k, 24);
    apb(0, 12'h010, 32'h0);
    chk(er, 1);
    $display("reject test done");
  endtask
  task t_busy;
    sel_drv_busy <= 1;
    sel_bad <= 1;
    sel_pend_st <= 8'h04;
    sel;
    chk(st_byte, 8'h14);
    sd(0, 8'h80);
    sel_cu_busy <= 1;
    sel;
    chk(st_byte, 8'h50);
    $display("busy test done");
  endtask
  task t_late;
    sel;
    chk(st_byte, 8'h00);
    sd(0, 8'h00);
    err_equip <= 1;
    err_corr <= 1;
    endp;
    chk(stop_xfer, 0);
    end_ce <= 1;
    end_de <= 1;
    endp;
    chk(st_byte, 8'h0E);
    sd(0, 8'h18);
    sd(2, 8'h40);
    sel;
    ex_event <= 1;
    endp;
    end_ce <= 1;
    end_de <= 1;
    endp;
    chk(st_byte, 8'h0D);
    chk(chain_sup, 1);
    sd(0, 8'h00);
    $display("ending test done");
  endtask
  task t_shared;
    apb(1, `A_CTRL, 32'h1);
    sel;
    err_overrun <= 1;
    err_count <= 1;
    endp;
    chk(stop_xfer, 1);
    end_ce <= 1;
    endp;
    chk(st_byte, 8'h0A);
    chk(hold_path, 1);
    sd(0, 8'h0C);
    de_accept <= 1;
    endp;
    chk(hold_path, 0);
    apb(1, `A_CTRL, 32'h0);
    sel_not_ready <= 1;
    sel_sense <= 1;
    sel;
    chk(st_byte, 8'h00);
    sel_not_ready <= 1;
    sel;
    chk(st_byte, 8'h02);
    sd(0, 8'h40);
    end_ce <= 1;
    end_de <= 1;
    endp;
    chk(st_byte, 8'h0C);
    err_parity <= 1;
    endp;
    chk(st_byte, 8'h22);
    $display("shared test done");
  endtask
  task t_misc;
    sel_no_data <= 1;
    sel;
    chk(st_byte, 8'h0C);
    chk(chain_sup, 0);
    sel_no_data <= 0;
    sel_diag <= 1;
    sel;
    chk(st_byte, 8'h02);
    sd(0, 8'h40);
    sel_diag <= 0;
    err_key <= 1;
    endp;
    chk(st_byte, 8'h02);
    err_equip <= 1;
    err_fatal <= 1;
    endp;
    chk(stop_xfer, 1);
    chk(st_byte, 8'h22);
    sd(0, 8'h50);
    $display("misc test done");
  endtask
  initial begin
    repeat (6) tick;
    srst <= 0;
    tick;
    t_reject;
    t_busy;
    t_late;
    t_shared;
    t_misc;
    summarize;
  end
endmodule
`default_nettype wire
